// File: rtl/sslp_pkg.sv
// Purpose: Shared constants and types for the strap-sampling status pin block
// Assumes: Single 100 MHz core clock, synchronous active-low resets
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave
`default_nettype none
package sslp_pkg;

    localparam int unsigned NUM_PINS        = 2;
    localparam int unsigned SEL_W           = 3;
    localparam int unsigned ADDR_W          = 5;

    // Vendor management register holding the event selection, bank zero
    localparam logic [4:0]  EVT_SEL_REG_NUM = 5'h14;
    localparam logic [0:0]  EVT_SEL_BANK    = 1'h0;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_EVT_SEL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_STRAP   = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_EVENTS  = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 5'h0C;

    // Event select field layout: pin n selector at bits [4n+2:4n]
    localparam int unsigned SEL_STRIDE      = 4;
    localparam logic [31:0] EVT_SEL_RESET   = 32'h0000_0010;
    localparam logic [1:0]  STRAP_RESET     = 2'h0;

    // Control register fields
    localparam int unsigned CTRL_SWRST_BIT  = 0;

    // Timing: software reset pulse length
    localparam int unsigned SWRST_TIME_NS   = 100;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam logic [3:0]  SWRST_CYCLES    =
        4'((SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [1:0]  AXI_OKAY        = 2'h0;
    localparam logic [1:0]  AXI_SLVERR      = 2'h2;

    typedef enum logic [2:0] {
        SSLP_EVT_LINK     = 3'h0,
        SSLP_EVT_ACTIVITY = 3'h1,
        SSLP_EVT_TX       = 3'h2,
        SSLP_EVT_RX       = 3'h3,
        SSLP_EVT_COL      = 3'h4,
        SSLP_EVT_SPEED    = 3'h5,
        SSLP_EVT_DUPLEX   = 3'h6
    } sslp_evt_t;

    typedef enum logic [1:0] {
        SSLP_ST_STRAP = 2'h0,
        SSLP_ST_DRIVE = 2'h1,
        SSLP_ST_SWRST = 2'h2
    } sslp_state_t;

    // Link status events bundled together
    typedef struct packed {
        logic link;
        logic activity;
        logic tx;
        logic rx;
        logic col;
        logic speed;
        logic duplex;
    } sslp_status_t;

    // Output and enable pair for a two-way pin group
    typedef struct packed {
        logic [NUM_PINS-1:0] o;
        logic [NUM_PINS-1:0] oe;
    } sslp_pin_drv_t;

endpackage : sslp_pkg
`default_nettype wire

// File: rtl/sslp_event_mux.sv
// Purpose: Picks the link status event shown on one status pin
// Assumes: Selector codes beyond duplex show nothing
// Notes:   Purely combinational
`timescale 1ns/1ns
`default_nettype none
module sslp_event_mux
    import sslp_pkg::*;
(
    // Event inputs
    input  wire sslp_status_t      status_in,
    input  wire logic [SEL_W-1:0]  sel_in,
    // Selected event
    output logic                   active_out
);

    wire sslp_evt_t evt_sel = sslp_evt_t'(sel_in);

    assign active_out = (evt_sel == SSLP_EVT_LINK)     ? status_in.link     :
                        (evt_sel == SSLP_EVT_ACTIVITY) ? status_in.activity :
                        (evt_sel == SSLP_EVT_TX)       ? status_in.tx       :
                        (evt_sel == SSLP_EVT_RX)       ? status_in.rx       :
                        (evt_sel == SSLP_EVT_COL)      ? status_in.col      :
                        (evt_sel == SSLP_EVT_SPEED)    ? status_in.speed    :
                        (evt_sel == SSLP_EVT_DUPLEX)   ? status_in.duplex   :
                        1'b0;

endmodule : sslp_event_mux
`default_nettype wire

// File: rtl/sslp_status_pins.sv
// Purpose: Strap capture and LED drive for two multi-function pins
// Assumes: Pin inputs synchronous to mclk_in; rstn_in covers power-on
// Notes:   Event select register stands in for vendor register 20
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module sslp_status_pins
    import sslp_pkg::*;
(
    // Clock and resets
    input  wire logic                 mclk_in,
    input  wire logic                 rstn_in,
    // Status strap pins, split three ways
    input  wire logic [NUM_PINS-1:0]  status_strap_pin_in,
    output logic      [NUM_PINS-1:0]  status_strap_pin_out,
    output logic      [NUM_PINS-1:0]  status_strap_pin_oe_out,
    // Link status events from the PHY core
    input  wire sslp_status_t         status_in,
    // Strap results and software reset pulse
    output logic      [NUM_PINS-1:0]  mgmt_addr_out,
    output logic                      data_if_tristate_out,
    output logic                      sw_reset_out,
    // AXI4-Lite write address
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // AXI4-Lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic      [1:0]           s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    // AXI4-Lite read data
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic      [31:0]          s_axi_rdata,
    output logic      [1:0]           s_axi_rresp
);

    ////////////////////////////////////////////////////////////////////////
    // State and registers

    sslp_state_t          state_reg;
    sslp_state_t          state_next;
    logic [NUM_PINS-1:0]  strap_reg;
    logic [31:0]          evt_sel_reg;
    logic [3:0]           swrst_cnt_reg;
    sslp_pin_drv_t        drv_reg;
    sslp_pin_drv_t        drv_next;
    logic                 tristate_reg;
    logic                 swrst_reg;

    logic                 aw_held_reg;
    logic                 w_held_reg;
    logic [ADDR_W-1:0]    aw_addr_reg;
    logic [31:0]          w_data_reg;
    logic [3:0]           w_strb_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic                 rvalid_reg;
    logic [31:0]          rdata_reg;
    logic [1:0]           rresp_reg;
    logic                 awready_reg;
    logic                 wready_reg;
    logic                 arready_reg;

    ////////////////////////////////////////////////////////////////////////
    // Event selection per pin

    logic [NUM_PINS-1:0]  evt_active;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            sslp_event_mux u_mux (
                .status_in  (status_in),
                .sel_in     (evt_sel_reg[gi*SEL_STRIDE +: SEL_W]),
                .active_out (evt_active[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Strap and drive sequencing

    wire in_strap  = (state_reg == SSLP_ST_STRAP);
    wire swrst_hit;
    wire swrst_done = (swrst_cnt_reg == 4'h1);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SSLP_ST_STRAP: begin
                state_next = SSLP_ST_DRIVE;
            end
            SSLP_ST_DRIVE: begin
                if (swrst_hit) begin
                    state_next = SSLP_ST_SWRST;
                end
            end
            SSLP_ST_SWRST: begin
                if (swrst_done) begin
                    state_next = SSLP_ST_DRIVE;
                end
            end
            default: begin
                state_next = SSLP_ST_DRIVE;
            end
        endcase
    end

    // Lit level is the inverse of the strap; dark level equals it
    always_comb begin
        drv_next.o  = strap_reg ^ evt_active;
        drv_next.oe = {NUM_PINS{1'b1}};
        if (in_strap) begin
            drv_next.o  = strap_reg;
            drv_next.oe = '0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            state_reg <= SSLP_ST_STRAP;
            drv_reg   <= '0;
        end else begin
            state_reg <= state_next;
            drv_reg   <= drv_next;
        end
    end

    // Captured at the first edge after release; only hardware reset gets here
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            strap_reg    <= STRAP_RESET;
            tristate_reg <= 1'b0;
        end else if (in_strap) begin
            strap_reg    <= status_strap_pin_in;
            tristate_reg <= (status_strap_pin_in == '0);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            swrst_cnt_reg <= '0;
            swrst_reg     <= 1'b0;
        end else if (swrst_hit && !in_strap) begin
            swrst_cnt_reg <= SWRST_CYCLES;
            swrst_reg     <= 1'b1;
        end else if (swrst_cnt_reg != '0) begin
            swrst_cnt_reg <= swrst_cnt_reg - 4'h1;
            swrst_reg     <= !swrst_done;
        end
    end

    assign status_strap_pin_out    = drv_reg.o;
    assign status_strap_pin_oe_out = drv_reg.oe;
    assign mgmt_addr_out           = strap_reg;
    assign data_if_tristate_out    = tristate_reg;
    assign sw_reset_out            = swrst_reg;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    wire aw_take   = s_axi_awvalid && s_axi_awready;
    wire w_take    = s_axi_wvalid && s_axi_wready;
    wire aw_have   = aw_held_reg || aw_take;
    wire w_have    = w_held_reg || w_take;
    wire wr_fire   = aw_have && w_have && !bvalid_reg;
    // Next handshake state, so the ready outputs can come from flops
    wire aw_held_next = aw_have && !wr_fire;
    wire w_held_next  = w_have && !wr_fire;
    wire bvalid_next  = wr_fire || (bvalid_reg && !s_axi_bready);
    wire [ADDR_W-1:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0]       wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wire [3:0]        wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    wire wr_sel    = wr_fire && (wr_addr == OFF_EVT_SEL);
    wire wr_ctrl   = wr_fire && (wr_addr == OFF_CTRL);
    wire wr_ok     = (wr_addr == OFF_EVT_SEL) || (wr_addr == OFF_CTRL)
                  || (wr_addr == OFF_STRAP) || (wr_addr == OFF_EVENTS);
    assign swrst_hit = wr_ctrl && wr_strb[0] && wr_data[CTRL_SWRST_BIT];

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg  <= w_held_next;
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    // Readies loaded with what a live decode would show next; same timing
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
        end else begin
            awready_reg <= !aw_held_next && !bvalid_next;
            wready_reg  <= !w_held_next && !bvalid_next;
        end
    end

    // Software reset leaves the selection alone; only hardware reset reloads its default, EVT_SEL_RESET
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            evt_sel_reg <= EVT_SEL_RESET;
        end else if (wr_sel) begin
            for (int b = 0; b < 4; b++) begin
                if (wr_strb[b]) begin
                    evt_sel_reg[b*8 +: 8] <= wr_data[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= AXI_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
    wire [31:0] rd_word =
        (s_axi_araddr == OFF_EVT_SEL) ? evt_sel_reg :
        (s_axi_araddr == OFF_STRAP)   ? {29'h0, tristate_reg, strap_reg} :
        (s_axi_araddr == OFF_EVENTS)  ? {25'h0, status_in} :
        (s_axi_araddr == OFF_CTRL)    ? {31'h0, swrst_reg} :
        32'h0000_0000;
    wire rd_ok = (s_axi_araddr == OFF_EVT_SEL) || (s_axi_araddr == OFF_STRAP)
              || (s_axi_araddr == OFF_EVENTS) || (s_axi_araddr == OFF_CTRL);

    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= AXI_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Refuse a new read while the answer is still pending
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            arready_reg <= 1'b1;
        end else begin
            arready_reg <= !rvalid_next;
        end
    end

endmodule : sslp_status_pins
`default_nettype wire

// File: verif/sslp_board_model.sv
// Purpose: Board strap resistors and status LEDs on the two pins
// Assumes: One pull resistor per pin, no floating pads
// Notes:   A released pad settles to its pull level
`timescale 1ns/1ns
`default_nettype none
module sslp_board_model
    import sslp_pkg::*;
(
    // Strap pull per pin
    input  wire logic [NUM_PINS-1:0] pull_level_in,
    // Device side of the pads
    input  wire logic [NUM_PINS-1:0] drv_in,
    input  wire logic [NUM_PINS-1:0] oe_in,
    // Resolved pad level
    output logic      [NUM_PINS-1:0] pad_out
);
    // Pull wins only while the device lets go
    assign pad_out = (oe_in & drv_in) | (~oe_in & pull_level_in);
endmodule : sslp_board_model
`default_nettype wire

// File: verif/sslp_status_pins_chk.sv
// Purpose: Port-level checks for the strap and status pin block
// Assumes: Single clock, rstn_in synchronous active low
// Notes:   Bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module sslp_status_pins_chk
    import sslp_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk_in,
    input  wire logic                rstn_in,
    // Observed ports
    input  wire sslp_status_t        status_in,
    input  wire logic [NUM_PINS-1:0] status_strap_pin_out,
    input  wire logic [NUM_PINS-1:0] status_strap_pin_oe_out,
    input  wire logic [NUM_PINS-1:0] mgmt_addr_out,
    input  wire logic                data_if_tristate_out,
    input  wire logic                sw_reset_out,
    input  wire logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [1:0]          s_axi_bresp,
    input  wire logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [31:0]         s_axi_rdata
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////////////
    property p_strap_input;
        !$past(rstn_in, 2) |-> status_strap_pin_oe_out == 2'h0;
    endproperty
    a_strap_input: assert property (p_strap_input)
        else $error("pin driven on reset exit");
    property p_drive;
        $past(rstn_in, 2) |-> status_strap_pin_oe_out == 2'h3;
    endproperty
    a_drive: assert property (p_drive)
        else $error("pin not driven after capture");
    property p_swrst_out;
        sw_reset_out |-> status_strap_pin_oe_out == 2'h3;
    endproperty
    a_swrst_out: assert property (p_swrst_out)
        else $error("pin released in software reset");
    property p_addr_hold;
        $past(rstn_in, 2) |-> $stable(mgmt_addr_out);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address changed outside reset");
    property p_tristate;
        $past(rstn_in) |-> data_if_tristate_out == (mgmt_addr_out == 2'h0);
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("tristate does not match address");
    property p_dark;
        status_strap_pin_oe_out == 2'h3 && $past(status_in) == 7'h00
            |-> status_strap_pin_out == mgmt_addr_out;
    endproperty
    a_dark: assert property (p_dark)
        else $error("pin lit with no event");
    property p_swrst_len;
        $rose(sw_reset_out) |-> sw_reset_out [*8] ##1 sw_reset_out ##1 sw_reset_out
            ##1 !sw_reset_out;
    endproperty
    a_swrst_len: assert property (p_swrst_len)
        else $error("software reset pulse length wrong");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped early");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read data dropped early");
endmodule : sslp_status_pins_chk
bind sslp_status_pins sslp_status_pins_chk u_sslp_status_pins_chk (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .status_in(status_in),
    .status_strap_pin_out(status_strap_pin_out),
    .status_strap_pin_oe_out(status_strap_pin_oe_out), .mgmt_addr_out(mgmt_addr_out),
    .data_if_tristate_out(data_if_tristate_out), .sw_reset_out(sw_reset_out),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// File: verif/sslp_status_pins_tb_top.sv
// Purpose: Self-checking bench for strap capture and status pin drive
// Assumes: 100 MHz clock; bus tasks take handshakes at the rising edge
// Notes:   Board model holds each pad at its pull level while released
`timescale 1ns/1ns
`default_nettype none
module sslp_status_pins_tb_top;
    import sslp_pkg::*;
    logic         mclk_in = 1'b0;
    logic         rstn_in = 1'b0;
    logic [1:0]   pull_lvl = 2'h0;
    logic [1:0]   pad, pin_o, pin_oe, addr, bresp, rresp;
    sslp_status_t status = '0;
    logic         tri_st, swrst, awr, wr, bv, arr, rv;
    logic         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [4:0]   awa = 5'h00, ara = 5'h00;
    logic [31:0]  wd = 32'h0, rd;
    logic [3:0]   ws = 4'hF;
    int           miscompares = 0, compares = 0, sw_cnt = 0;
    ////////////////////////////////////////////////////////////////////////////
    sslp_status_pins u_sslp_status_pins (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .status_strap_pin_in(pad), .status_strap_pin_out(pin_o),
        .status_strap_pin_oe_out(pin_oe), .status_in(status), .mgmt_addr_out(addr),
        .data_if_tristate_out(tri_st), .sw_reset_out(swrst),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));
    sslp_board_model u_sslp_board_model (.pull_level_in(pull_lvl), .drv_in(pin_o),
        .oe_in(pin_oe), .pad_out(pad));
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    always @(negedge mclk_in) begin
        if (swrst === 1'b1) sw_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk_in);
        awv <= 1'b1;
        awa <= a;
        wv  <= 1'b1;
        wd  <= d;
        br  <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!(bv && br));
        r = bresp;
        br <= 1'b0;
    endtask : axi_wr
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk_in);
        arv <= 1'b1;
        ara <= a;
        rr  <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (arv && arr) arv <= 1'b0;
        end while (!(rv && rr));
        d = rd;
        r = rresp;
        rr <= 1'b0;
        chk("rdata", d, e);
        chk("rresp", 32'(r), 32'(er));
    endtask : rd_chk
    task automatic hw_reset(input logic [1:0] s);
        @(posedge mclk_in);
        rstn_in  <= 1'b0;
        pull_lvl <= s;
        repeat (8) @(posedge mclk_in);
        rstn_in <= 1'b1;
    endtask : hw_reset
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_straps;
        for (int s = 0; s < 4; s++) begin
            hw_reset(2'(s));
            // Strap cycle: pads still released while the level is taken
            repeat (2) @(negedge mclk_in);
            chk("oe_exit", 32'(pin_oe), 32'h0);
            chk("addr", 32'(addr), 32'(s));
            chk("tristate", 32'(tri_st), 32'(s == 0));
            @(negedge mclk_in);
            chk("oe_run", 32'(pin_oe), 32'h3);
            chk("pad_dark", 32'(pad), 32'(s));
            rd_chk(OFF_STRAP, {29'h0, s == 0, 2'(s)}, AXI_OKAY);
            rd_chk(OFF_EVT_SEL, EVT_SEL_RESET, AXI_OKAY);
        end
    endtask : t_straps
    task automatic t_events;
        logic [1:0] r;
        hw_reset(2'h2);
        repeat (3) @(posedge mclk_in);
        for (int k = 0; k < 8; k++) begin
            axi_wr(OFF_EVT_SEL, 32'(k * 17), r);
            chk("bresp", 32'(r), 32'(AXI_OKAY));
            status <= (k < 7) ? 7'h40 >> k : 7'h7F;
            repeat (3) @(negedge mclk_in);
            chk("pin_on", 32'(pin_o), (k < 7) ? 32'h1 : 32'h2);
            rd_chk(OFF_EVENTS, 32'(status), AXI_OKAY);
            status <= ~status;
            repeat (3) @(negedge mclk_in);
            chk("pin_off", 32'(pin_o), 32'h2);
        end
        status <= '0;
    endtask : t_events
    task automatic t_unmapped;
        logic [1:0] r;
        axi_wr(5'h10, 32'hFF, r);
        chk("bresp_err", 32'(r), 32'(AXI_SLVERR));
        rd_chk(5'h10, 32'h0, AXI_SLVERR);
        // Low byte lane off: a control write must not start a reset
        ws <= 4'hE;
        sw_cnt = 0;
        axi_wr(OFF_CTRL, 32'h1, r);
        ws <= 4'hF;
        chk("bresp_ctrl", 32'(r), 32'(AXI_OKAY));
        repeat (3) @(negedge mclk_in);
        chk("swrst_masked", 32'(sw_cnt), 32'h0);
    endtask : t_unmapped
    task automatic t_swrst;
        logic [1:0] r;
        // Both pins lit, so a resample would capture the lit level
        axi_wr(OFF_EVT_SEL, 32'h0000_0011, r);
        status <= 7'h7F;
        sw_cnt = 0;
        axi_wr(OFF_CTRL, 32'h1, r);
        chk("bresp_swrst", 32'(r), 32'(AXI_OKAY));
        // Pulls flip mid-reset; a released pad or a resample would show
        pull_lvl <= 2'h1;
        @(negedge mclk_in);
        chk("swrst_on", 32'(swrst), 32'h1);
        chk("oe_kept", 32'(pin_oe), 32'h3);
        chk("pad_lit", 32'(pad), 32'h1);
        rd_chk(OFF_CTRL, 32'h1, AXI_OKAY);
        repeat (40) @(negedge mclk_in);
        chk("swrst_len", 32'(sw_cnt), 32'(SWRST_CYCLES));
        chk("addr_kept", 32'(addr), 32'h2);
        rd_chk(OFF_EVT_SEL, 32'h11, AXI_OKAY);
        rd_chk(OFF_STRAP, 32'h2, AXI_OKAY);
    endtask : t_swrst
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        t_straps;
        t_events;
        t_unmapped;
        t_swrst;
        test_done;
    end
    initial begin
        #50000;
        miscompares++;
        test_done;
    end
endmodule : sslp_status_pins_tb_top
`default_nettype wire
